// ### sysram_pkg.sv
// Constants for the dual-port system RAM: address map, bus codes and sizes.
// Assumes a single core clock; pin inputs are synchronised inside the core.
package sysram_pkg;

  // ---------------------------------------------------------------------------
  // Storage and address map
  // ---------------------------------------------------------------------------
  localparam int          RAM_WORDS   = 352;
  localparam int          RAM_AW      = 9;
  localparam int          CPU_W       = 16;
  localparam int          GFX_W       = 14;
  localparam logic [15:0] RAM_BASE    = 16'h0200;
  localparam logic [15:0] RAM_LAST    = 16'h035f;
  localparam int          GFX_WORDS   = 240;
  localparam int          LINE_WORDS  = 20;
  localparam int          CNT_W       = 8;
  localparam logic [7:0]  CNT_RESET   = 8'h00;
  localparam logic [7:0]  CNT_STEP    = 8'h01;

  // External graphics memory window on the 14-bit bus (address comparator)
  localparam logic [15:0] EXT_GFX_LO  = 16'h0000;
  localparam logic [15:0] EXT_GFX_HI  = 16'h003f;

  // ---------------------------------------------------------------------------
  // Bus control codes {direction, ctl_a, ctl_b}
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  CODE_IDLE          = 3'h0;
  localparam logic [2:0]  CODE_IAB           = 3'h1;
  localparam logic [2:0]  CODE_ADDR_INDIRECT = 3'h2;
  localparam logic [2:0]  CODE_READ_TO_BUS   = 3'h3;
  localparam logic [2:0]  CODE_ADDR_LATCH    = 3'h4;
  localparam logic [2:0]  CODE_WRITE_STROBE  = 3'h5;
  localparam logic [2:0]  CODE_WRITE_DATA    = 3'h6;
  localparam logic [2:0]  CODE_INTERRUPT_ACK = 3'h7;

  // Reset values
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [2:0]  CODE_RESET  = 3'h0;

endpackage : sysram_pkg

// ### sysram_store.sv
// Word store for the system RAM: one write port, one registered read port.
// Assumes addresses below the depth; contents are not cleared by reset.
`timescale 1ns/10ps
module sysram_store (
  input  wire logic                               core_clk_in,
  input  wire logic                               wr_en_in,
  input  wire logic [sysram_pkg::RAM_AW-1:0]      wr_addr_in,
  input  wire logic [sysram_pkg::CPU_W-1:0]       wr_data_in,
  input  wire logic [sysram_pkg::RAM_AW-1:0]      rd_addr_in,
  output logic      [sysram_pkg::CPU_W-1:0]       rd_data_out
);

  logic [sysram_pkg::CPU_W-1:0] mem_reg [0:sysram_pkg::RAM_WORDS-1];

  // ---------------------------------------------------------------------------
  // Write and registered read
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    rd_data_out <= mem_reg[rd_addr_in];
  end

endmodule : sysram_store

// ### sysram_dual_port.sv
// Dual-port system RAM between a multiplexed 16-bit processor bus and a
// 14-bit graphics bus, with copy mode, DMA line-buffer fill and recirculation.
// Assumes all pins are asynchronous to core_clk_in and far slower than it.
//
// Behaviour
// - 352 words answering addresses 512 to 863
// - Graphics side sees low 14 bits only
// - Shared 16-bit bus for address and data
// - Decode 3-bit control code into strobes
// - Twenty-entry 14-bit line buffer feeds graphics
// - Interrupt-acknowledge code enters copy mode
// - Copy mode drives processor low bits to graphics
// - External graphics read reverses copy direction
// - First grant-acknowledge falling edge ends copy
// - Grant acknowledge resets sync, selects counter
// - Interrupt decode clears graphics address counter
// - Row strobe high drives graphics bus
// - Strobe fall tri-states output, shifts buffer
// - Counter steps only while grant acknowledged low
// - Recirculate buffer between DMA cycles
// - Each DMA advances counter by twenty
// - Address phase captures whole bus value
`timescale 1ns/10ps
module sysram_dual_port (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        bus_direction_ctl_in,
  input  wire logic        bus_ctl_a_in,
  input  wire logic        bus_ctl_b_in,
  input  wire logic [15:0] cpu_bus_bit_in,
  output logic      [15:0] cpu_bus_bit_out,
  output logic             cpu_bus_bit_oe_out,
  input  wire logic [13:0] graphics_bus_bit_in,
  output logic      [13:0] graphics_bus_bit_out,
  output logic             graphics_bus_bit_oe_out,
  input  wire logic        row_strobe_in,
  input  wire logic        bus_grant_ack_n_in,
  output logic             copy_mode_out
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction : in_window

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0]  code_meta_reg;
  logic [2:0]  code_reg;
  logic [15:0] cpu_meta_reg;
  logic [15:0] cpu_sync_reg;
  logic [13:0] gfx_meta_reg;
  logic [13:0] gfx_sync_reg;
  logic        strobe_meta_reg;
  logic        strobe_reg;
  logic        strobe_dly_reg;
  logic        grant_n_meta_reg;
  logic        grant_n_reg;
  logic        grant_n_dly_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      code_meta_reg    <= sysram_pkg::CODE_RESET;
      code_reg         <= sysram_pkg::CODE_RESET;
      cpu_meta_reg     <= 16'h0000;
      cpu_sync_reg     <= 16'h0000;
      gfx_meta_reg     <= 14'h0000;
      gfx_sync_reg     <= 14'h0000;
      strobe_meta_reg  <= 1'b0;
      strobe_reg       <= 1'b0;
      strobe_dly_reg   <= 1'b0;
      grant_n_meta_reg <= 1'b1;
      grant_n_reg      <= 1'b1;
      grant_n_dly_reg  <= 1'b1;
    end else begin
      code_meta_reg    <= {bus_direction_ctl_in, bus_ctl_a_in, bus_ctl_b_in};
      code_reg         <= code_meta_reg;
      cpu_meta_reg     <= cpu_bus_bit_in;
      cpu_sync_reg     <= cpu_meta_reg;
      gfx_meta_reg     <= graphics_bus_bit_in;
      gfx_sync_reg     <= gfx_meta_reg;
      strobe_meta_reg  <= row_strobe_in;
      strobe_reg       <= strobe_meta_reg;
      strobe_dly_reg   <= strobe_reg;
      grant_n_meta_reg <= bus_grant_ack_n_in;
      grant_n_reg      <= grant_n_meta_reg;
      grant_n_dly_reg  <= grant_n_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Code decode
  // ---------------------------------------------------------------------------
  logic        addr_phase;
  logic        read_to_bus_code;
  logic        write_strobe_code;
  logic        interrupt_ack_code;
  logic        strobe_fall;
  logic        grant_fall;
  logic        dma_active;

  always_comb begin
    addr_phase         = 1'b0;
    read_to_bus_code   = 1'b0;
    write_strobe_code  = 1'b0;
    interrupt_ack_code = 1'b0;
    case (code_reg)
      sysram_pkg::CODE_ADDR_LATCH,
      sysram_pkg::CODE_ADDR_INDIRECT: addr_phase         = 1'b1;
      sysram_pkg::CODE_READ_TO_BUS:   read_to_bus_code   = 1'b1;
      sysram_pkg::CODE_WRITE_STROBE:  write_strobe_code  = 1'b1;
      sysram_pkg::CODE_INTERRUPT_ACK: interrupt_ack_code = 1'b1;
      default:                        addr_phase         = 1'b0;
    endcase
  end

  assign strobe_fall = strobe_dly_reg && !strobe_reg;
  assign grant_fall  = grant_n_dly_reg && !grant_n_reg;
  assign dma_active  = !grant_n_reg;

  // ---------------------------------------------------------------------------
  // Address register
  // ---------------------------------------------------------------------------
  logic [15:0] addr_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      addr_reg <= sysram_pkg::ADDR_RESET;
    end else if (addr_phase) begin
      addr_reg <= cpu_sync_reg;
    end
  end

  logic own_hit;
  logic ext_gfx_hit;

  assign own_hit     = in_window(addr_reg, sysram_pkg::RAM_BASE, sysram_pkg::RAM_LAST);
  assign ext_gfx_hit = in_window(addr_reg, sysram_pkg::EXT_GFX_LO, sysram_pkg::EXT_GFX_HI);

  // ---------------------------------------------------------------------------
  // Interrupt synchroniser and copy mode
  // ---------------------------------------------------------------------------
  logic ack_seen_reg;
  logic int_pulse;
  logic copy_reg;
  logic reversal;

  assign int_pulse = interrupt_ack_code && !ack_seen_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_seen_reg <= 1'b0;
    end else if (dma_active) begin
      ack_seen_reg <= 1'b0;
    end else if (interrupt_ack_code) begin
      ack_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      copy_reg <= 1'b0;
    end else if (int_pulse) begin
      copy_reg <= 1'b1;
    end else if (grant_fall) begin
      copy_reg <= 1'b0;
    end
  end

  assign reversal      = copy_reg && read_to_bus_code && ext_gfx_hit;
  assign copy_mode_out = copy_reg;

  // ---------------------------------------------------------------------------
  // Graphics address counter
  // ---------------------------------------------------------------------------
  logic [sysram_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= sysram_pkg::CNT_RESET;
    end else if (int_pulse) begin
      cnt_reg <= sysram_pkg::CNT_RESET;
    end else if (strobe_fall && dma_active) begin
      cnt_reg <= cnt_reg + sysram_pkg::CNT_STEP;
    end
  end

  // ---------------------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------------------
  logic [sysram_pkg::RAM_AW-1:0] cpu_index;
  logic [sysram_pkg::RAM_AW-1:0] rd_index;
  logic [15:0]                   cpu_offset;
  logic [15:0]                   rd_word;
  logic                          wr_en;

  assign cpu_offset = addr_reg - sysram_pkg::RAM_BASE;
  assign cpu_index  = cpu_offset[sysram_pkg::RAM_AW-1:0];
  assign rd_index   = dma_active ? {1'b0, cnt_reg} : cpu_index;
  assign wr_en      = write_strobe_code && own_hit && !dma_active;

  sysram_store u_store (
    .core_clk_in (core_clk_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (cpu_index),
    .wr_data_in  (cpu_sync_reg),
    .rd_addr_in  (rd_index),
    .rd_data_out (rd_word)
  );

  // ---------------------------------------------------------------------------
  // Line buffer
  // ---------------------------------------------------------------------------
  logic [13:0] line_reg [0:sysram_pkg::LINE_WORDS-1];
  logic [13:0] line_in;

  assign line_in = dma_active ? rd_word[13:0] : line_reg[0];

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < sysram_pkg::LINE_WORDS; i++) begin
        line_reg[i] <= 14'h0000;
      end
    end else if (strobe_fall) begin
      for (int i = 0; i < sysram_pkg::LINE_WORDS - 1; i++) begin
        line_reg[i] <= line_reg[i+1];
      end
      line_reg[sysram_pkg::LINE_WORDS-1] <= line_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus drivers
  // ---------------------------------------------------------------------------
  logic [15:0] cpu_out_reg;
  logic [13:0] gfx_out_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cpu_out_reg <= 16'h0000;
    end else if (reversal) begin
      cpu_out_reg <= {2'b00, gfx_sync_reg};
    end else begin
      cpu_out_reg <= rd_word;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      gfx_out_reg <= 14'h0000;
    end else if (copy_reg) begin
      gfx_out_reg <= cpu_sync_reg[13:0];
    end else if (dma_active) begin
      gfx_out_reg <= rd_word[13:0];
    end else begin
      gfx_out_reg <= line_reg[0];
    end
  end

  assign cpu_bus_bit_out         = cpu_out_reg;
  assign cpu_bus_bit_oe_out      = reversal || (read_to_bus_code && own_hit && !dma_active);
  assign graphics_bus_bit_out    = gfx_out_reg;
  assign graphics_bus_bit_oe_out = copy_reg ? !reversal : strobe_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_CPU_IDLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !reversal && !(read_to_bus_code && own_hit) |-> !cpu_bus_bit_oe_out)
    else $error("Processor bus driven outside window");

  AST_GFX_LOW: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !copy_reg && !strobe_reg |-> !graphics_bus_bit_oe_out)
    else $error("Graphics bus driven while strobe low");

  AST_CNT_CLEAR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    int_pulse |=> cnt_reg == 8'h00)
    else $error("Counter not cleared on interrupt");

  AST_CNT_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    grant_n_reg && !int_pulse |=> cnt_reg == $past(cnt_reg))
    else $error("Counter moved while grant high");

  AST_CNT_STEP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    strobe_fall && !grant_n_reg && !int_pulse |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("Counter missed strobe step");

  AST_COPY_ENTER: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    int_pulse |=> copy_mode_out ##1 (copy_mode_out || $past(grant_fall)))
    else $error("Copy mode not entered");

  AST_COPY_EXIT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    grant_fall && !int_pulse |=> !copy_mode_out)
    else $error("Copy mode not left");

  AST_REVERSE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reversal |-> cpu_bus_bit_oe_out && !graphics_bus_bit_oe_out)
    else $error("Reversal drivers wrong");

  AST_ADDR_CAPTURE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    addr_phase |=> addr_reg == $past(cpu_sync_reg))
    else $error("Address not captured");

  AST_COPY_DATA: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    copy_reg |=> graphics_bus_bit_out == $past(cpu_sync_reg[13:0]))
    else $error("Copy data mismatch");

  AST_RECIRC: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    strobe_fall && grant_n_reg |=> line_reg[19] == $past(line_reg[0]))
    else $error("Line buffer not recirculated");

endmodule : sysram_dual_port

// ### gfx_ctl_model.sv
// Behavioural graphics controller: row-strobe bursts and one external
// graphics memory word. Assumes the bench pulses start_in for one cycle.
`timescale 1ns/10ps
module gfx_ctl_model (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic [3:0]  width_in,
  input  wire logic        ext_sel_in,
  input  wire logic [13:0] ext_word_in,
  output logic             row_strobe_out,
  output logic      [13:0] ext_bus_out,
  output logic             ext_oe_out,
  output logic             busy_out
);
  logic [4:0] cnt_reg;
  logic [4:0] pulse_reg;

  // ---------------------------------------------------------------------------
  // Burst of strobe pulses, high and low for width_in cycles each
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_out       <= 1'b0;
      row_strobe_out <= 1'b0;
      cnt_reg        <= 5'h00;
      pulse_reg      <= 5'h00;
    end else if (!busy_out) begin
      row_strobe_out <= 1'b0;
      cnt_reg        <= 5'h00;
      pulse_reg      <= 5'h00;
      busy_out       <= start_in; // One burst per character row
    end else begin
      row_strobe_out <= (cnt_reg < {1'b0, width_in});
      if (cnt_reg == {width_in, 1'b0} - 5'h01) begin
        cnt_reg   <= 5'h00;
        pulse_reg <= pulse_reg + 5'h01;
        if (pulse_reg == 5'h13) begin
          busy_out <= 1'b0; // Twenty pulses per burst
        end
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // External graphics memory answers only when selected
  assign ext_bus_out = ext_word_in;
  assign ext_oe_out  = ext_sel_in;
endmodule : gfx_ctl_model

// ### dual_port_system_ram_tb.sv
// Self-checking bench for the dual-port system RAM.
// Assumes sysram_pkg, sysram_store, sysram_dual_port and gfx_ctl_model.
`timescale 1ns/10ps
module dual_port_system_ram_tb;
  localparam int CYC_LIMIT = 10000;
  logic        core_clk_in;
  logic        sys_rst_in;
  logic [2:0]  bus_code;
  logic [15:0] cpu_drv;
  logic [15:0] cpu_wire;
  logic [15:0] cpu_out;
  logic        cpu_oe;
  logic [13:0] gfx_wire;
  logic [13:0] gfx_out;
  logic        gfx_oe;
  logic        row_strobe;
  logic        grant_n;
  logic        copy_mode;
  logic        start;
  logic        ext_sel;
  logic        ext_oe;
  logic        busy;
  logic        toggle;
  logic [3:0]  width;
  logic [13:0] ext_word;
  logic [13:0] ext_bus;
  int          error_cnt;
  int          checks;
  int          cyc;

  // ---------------------------------------------------------------------------
  // Wire levels; a released graphics bus shows a changing pattern
  // ---------------------------------------------------------------------------
  assign cpu_wire = cpu_oe ? cpu_out : cpu_drv;
  assign gfx_wire = gfx_oe ? gfx_out : (ext_oe ? ext_bus : {7{toggle, ~toggle}});

  sysram_dual_port i_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .bus_direction_ctl_in(bus_code[2]), .bus_ctl_a_in(bus_code[1]), .bus_ctl_b_in(bus_code[0]),
    .cpu_bus_bit_in(cpu_wire), .cpu_bus_bit_out(cpu_out), .cpu_bus_bit_oe_out(cpu_oe),
    .graphics_bus_bit_in(gfx_wire), .graphics_bus_bit_out(gfx_out), .graphics_bus_bit_oe_out(gfx_oe),
    .row_strobe_in(row_strobe), .bus_grant_ack_n_in(grant_n), .copy_mode_out(copy_mode));

  gfx_ctl_model i_gfx (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .start_in(start), .width_in(width),
    .ext_sel_in(ext_sel), .ext_word_in(ext_word), .row_strobe_out(row_strobe),
    .ext_bus_out(ext_bus), .ext_oe_out(ext_oe), .busy_out(busy));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] word_val(input int i);
    return 16'h8000 | ((16'(i) * 16'h0123 + 16'h0011) & 16'h3fff);
  endfunction : word_val

  task automatic bus_phase(input logic [2:0] code, input logic [15:0] val);
    bus_code = code;
    cpu_drv  = val;
    tick(5);
  endtask : bus_phase

  task automatic write_word(input logic [15:0] addr, input logic [15:0] data);
    bus_phase(sysram_pkg::CODE_ADDR_LATCH, addr);
    bus_phase(sysram_pkg::CODE_WRITE_STROBE, data);
    bus_phase(sysram_pkg::CODE_IDLE, ~data);
  endtask : write_word

  task automatic read_word(input logic [15:0] addr, input logic [15:0] exp, input logic hit);
    bus_phase(sysram_pkg::CODE_ADDR_LATCH, addr);
    bus_phase(sysram_pkg::CODE_READ_TO_BUS, ~addr);
    check("cpu_oe_read", {15'h0000, cpu_oe}, {15'h0000, hit});
    if (hit) check("cpu_read_data", cpu_out, exp);
    bus_phase(sysram_pkg::CODE_IDLE, addr);
    check("cpu_oe_after", {15'h0000, cpu_oe}, 16'h0000);
  endtask : read_word

  task automatic wait_strobe(input logic want);
    int n;
    n = 0;
    while (row_strobe !== want && n < 100) begin
      tick(1);
      n++;
    end
    if (n >= 100) check("strobe_wait", 16'h0000, 16'h0001);
  endtask : wait_strobe

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    check("reset_oe", {14'h0000, cpu_oe, gfx_oe}, 16'h0000);
    check("reset_copy", {15'h0000, copy_mode}, 16'h0000);
  endtask : t_reset

  task automatic t_store();
    for (int i = 0; i < 40; i++) write_word(sysram_pkg::RAM_BASE + 16'(i), word_val(i));
    write_word(sysram_pkg::RAM_LAST, 16'h7e81);
    read_word(sysram_pkg::RAM_BASE, word_val(0), 1'b1);
    read_word(sysram_pkg::RAM_LAST, 16'h7e81, 1'b1);
    read_word(16'h0360, 16'h0000, 1'b0);
    read_word(16'h01ff, 16'h0000, 1'b0);
    bus_phase(sysram_pkg::CODE_ADDR_INDIRECT, sysram_pkg::RAM_BASE + 16'h0001);
    bus_phase(sysram_pkg::CODE_READ_TO_BUS, 16'h0000);
    check("indirect_oe", {15'h0000, cpu_oe}, 16'h0001);
    check("indirect_read", cpu_out, word_val(1));
    bus_phase(sysram_pkg::CODE_IDLE, 16'h0000);
  endtask : t_store

  task automatic t_copy();
    bus_phase(sysram_pkg::CODE_INTERRUPT_ACK, 16'h5a3c);
    check("copy_enter", {15'h0000, copy_mode}, 16'h0001);
    check("copy_gfx_oe", {15'h0000, gfx_oe}, 16'h0001);
    check("copy_gfx_data", {2'h0, gfx_out}, 16'h1a3c);
    bus_phase(sysram_pkg::CODE_IDLE, 16'hc3a5);
    check("copy_follow", {2'h0, gfx_out}, 16'h03a5);
    bus_phase(sysram_pkg::CODE_ADDR_LATCH, 16'h0010);
    ext_word = 14'h2b6d;
    ext_sel  = 1'b1;
    bus_phase(sysram_pkg::CODE_READ_TO_BUS, 16'h0f0f);
    check("rev_gfx_oe", {15'h0000, gfx_oe}, 16'h0000);
    check("rev_cpu_oe", {15'h0000, cpu_oe}, 16'h0001);
    check("rev_cpu_data", cpu_out, 16'h2b6d);
    bus_phase(sysram_pkg::CODE_IDLE, 16'h0f0f);
    ext_sel = 1'b0;
    grant_n = 1'b0;
    tick(5);
    check("copy_exit", {15'h0000, copy_mode}, 16'h0000);
  endtask : t_copy

  task automatic burst(input logic [3:0] w, input int base);
    width = w;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int k = 0; k < 20; k++) begin
      wait_strobe(1'b1);
      tick(int'(w) - 1);
      check("row_gfx_oe", {15'h0000, gfx_oe}, 16'h0001);
      check("row_gfx_data", {2'h0, gfx_out}, word_val(base + k) & 16'h3fff);
      wait_strobe(1'b0);
      tick(3);
      check("low_gfx_oe", {15'h0000, gfx_oe}, 16'h0000);
    end
  endtask : burst

  // ---------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    toggle <= ~toggle;
    cyc++;
    if (cyc == CYC_LIMIT) begin
      error_cnt++;
      $display("MISMATCH watchdog expected finish seen timeout");
      give_verdict();
    end
  end

  initial begin
    error_cnt  = 0;
    checks     = 0;
    cyc        = 0;
    toggle     = 1'b0;
    sys_rst_in = 1'b1;
    bus_code   = sysram_pkg::CODE_IDLE;
    cpu_drv    = 16'h0000;
    grant_n    = 1'b1;
    start      = 1'b0;
    width      = 4'h6;
    ext_sel    = 1'b0;
    ext_word   = 14'h0000;
    tick(12);
    sys_rst_in = 1'b0;
    tick(3);
    t_reset();
    t_store();
    t_copy();
    burst(4'h6, 0);
    grant_n = 1'b1;
    tick(6);
    burst(4'h8, 0);
    grant_n = 1'b0;
    tick(6);
    burst(4'h6, 20);
    write_word(sysram_pkg::RAM_BASE + 16'h0002, 16'h0000);
    read_word(sysram_pkg::RAM_BASE + 16'h0002, 16'h0000, 1'b0);
    grant_n = 1'b1;
    tick(6);
    read_word(sysram_pkg::RAM_BASE + 16'h0002, word_val(2), 1'b1);
    give_verdict();
  end
endmodule : dual_port_system_ram_tb
